// ---- design/event_delay.sv ----
// One-shot countdown that pulses done a set number of cycles after start
`timescale 1ns/10ps
module event_delay
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Control
    input  wire logic        start,
    input  wire logic [31:0] load,
    // Result
    output logic             busy,
    output logic             done
);

    logic [31:0] cnt_q;

    // Restart wins, so a fresh reference point moves the deadline
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cnt_q <= 32'h0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= (load == 32'h0) ? 32'h1 : load;
            busy  <= 1'b1;
            done  <= 1'b0;
        end
        else if (busy && cnt_q == 32'h1)
        begin
            busy <= 1'b0;
            done <= 1'b1;
        end
        else
        begin
            cnt_q <= busy ? cnt_q - 32'h1 : cnt_q;
            done  <= 1'b0;
        end
    end

endmodule // event_delay

// ---- design/radio_interrupt_event_unit.sv ----
// Interrupt event collection, timing and AXI4-Lite registers of the radio
`timescale 1ns/10ps
module radio_interrupt_event_unit
    import radio_irq_pkg::*;
#(
    parameter int CLK_STABLE_CYCLES = CLK_STABLE_CYC,
    parameter int DISC_FEC_CYCLES   = DISC_FEC_CYC,
    parameter int TX_FEC_CYCLES     = TX_FEC_WAKE_CYC,
    parameter int RX_FEC_CYCLES     = RX_FEC_PROC_CYC
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // AXI4-Lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Chip pin and power state
    input  wire logic        chip_reset_pin_n,
    input  wire logic        sleep_wake,
    // Radio core status
    input  wire logic        frame_delimiter,
    input  wire logic        addr_mismatch,
    input  wire logic        rx_frame_end,
    input  wire logic [11:0] frame_bytes,
    input  wire logic        rx_byte_stb,
    input  wire logic        tx_start,
    input  wire logic        tx_active,
    input  wire logic        rx_active,
    input  wire logic [8:0]  fifo_level,
    input  wire logic [25:0] evt_pulse,
    // Interrupt line
    output logic             irq_out_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0]         pin_sync_q;
    logic               pin_filt_q;
    logic [31:0]        src_q;
    logic [31:0]        en_q;
    logic               dac_q;
    logic               fec_q;
    rate_e              rate_q;
    logic [7:0]         trig_empty_q;
    logic [7:0]         trig_full_q;
    frame_state_e       fr_q;
    frame_state_e       fr_d;
    logic [31:0]        elapsed_q;
    logic [11:0]        rx_bytes_q;
    logic               rx_full_done_q;
    logic [8:0]         lvl_q;
    logic               aw_full_q;
    logic               w_full_q;
    logic [7:0]         wa_q;
    logic [31:0]        wd_q;
    logic [3:0]         ws_q;
    logic [NUM_TIMER-1:0] t_start;
    logic [NUM_TIMER-1:0] t_busy;
    logic [NUM_TIMER-1:0] t_done;
    logic [31:0]        t_load [NUM_TIMER];

    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    wire pin_settled = pin_sync_q[1] == pin_sync_q[2];
    wire pin_release = pin_settled & pin_sync_q[2] & ~pin_filt_q;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pin_sync_q <= 3'h0;
            pin_filt_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], chip_reset_pin_n};
            pin_filt_q <= pin_settled ? pin_sync_q[2] : pin_filt_q;
        end
    end

    // ------------------------------------------------------------
    // Symbol time and frame length
    // ------------------------------------------------------------
    // RULE12 - rate selects symbol
    wire [31:0] sym_cyc = (rate_q == RATE_50K)  ? 32'(SYM_50K_CYC)  :
                          (rate_q == RATE_200K) ? 32'(SYM_200K_CYC) :
                          (rate_q == RATE_400K) ? 32'(SYM_400K_CYC) :
                                                  32'(SYM_100K_CYC);
    // RULE7 - FEC doubles symbols
    wire [4:0]  bit_sh    = 5'(BITS_PER_BYTE_SH) + {4'h0, fec_q};
    wire [31:0] byte_cyc  = 32'({20'h0, frame_bytes} * sym_cyc);
    wire [31:0] proc_cyc  = fec_q ? 32'(DISC_FEC_CYCLES) : 32'(DISC_NOFEC_CYC);
    wire [31:0] frame_cyc = (byte_cyc << bit_sh) + proc_cyc;
    // Time already spent since the delimiter is not waited twice
    wire [31:0] disc_left = (frame_cyc > elapsed_q) ? frame_cyc - elapsed_q : 32'h1;

    // ------------------------------------------------------------
    // Frame tracking for address filtering
    // ------------------------------------------------------------
    wire in_frame  = fr_q == FR_RX;
    // RULE6 - immediate discard
    wire disc_now  = in_frame & addr_mismatch & ~dac_q;
    // RULE7 - discard after frame
    wire disc_wait = in_frame & addr_mismatch & dac_q;

    always_comb
    begin
        fr_d = fr_q;
        case (fr_q)
            FR_IDLE:
            begin
                if (frame_delimiter)
                    fr_d = FR_RX;
            end
            FR_RX:
            begin
                if (addr_mismatch)
                    fr_d = dac_q ? FR_HOLD : FR_IDLE;
                else if (rx_frame_end)
                    fr_d = FR_IDLE;
            end
            FR_HOLD:
            begin
                if (t_done[T_DISC])
                    fr_d = FR_IDLE;
            end
            default:
            begin
                fr_d = FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            fr_q      <= FR_IDLE;
            elapsed_q <= 32'h0;
        end
        else
        begin
            fr_q      <= fr_d;
            elapsed_q <= frame_delimiter ? 32'h1 : elapsed_q + {31'h0, in_frame};
        end
    end

    // ------------------------------------------------------------
    // FIFO trigger crossings
    // ------------------------------------------------------------
    wire [8:0] empty_lvl = {1'b0, trig_empty_q};
    wire [8:0] full_lvl  = {1'b0, trig_full_q};
    // RULE8 - TX empty after wake
    wire tx_empty_hit = tx_active & ~t_busy[T_TXF] & (lvl_q > empty_lvl)
                        & (fifo_level <= empty_lvl);
    // RULE9 - RX read below trigger
    wire rx_empty_hit = rx_active & (lvl_q >= empty_lvl) & (fifo_level < empty_lvl);
    // RULE10 - TX prep overfill
    wire tx_full_hit  = ~tx_active & ~rx_active & (lvl_q <= full_lvl)
                        & (fifo_level > full_lvl);
    // RULE11 - RX bytes past trigger
    wire rx_full_hit  = rx_active & ~rx_full_done_q & ({1'b0, rx_bytes_q} > {5'h0, full_lvl});

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            lvl_q          <= 9'h0;
            rx_bytes_q     <= 12'h0;
            rx_full_done_q <= 1'b0;
        end
        else
        begin
            lvl_q          <= fifo_level;
            rx_bytes_q     <= frame_delimiter ? 12'h0 : rx_bytes_q + {11'h0, rx_byte_stb};
            rx_full_done_q <= ~frame_delimiter & (rx_full_done_q | rx_full_hit);
        end
    end

    // ------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------
    // RULE5 - start on release or wake
    assign t_start[T_CLK]  = pin_release | sleep_wake;
    assign t_load[T_CLK]   = 32'(CLK_STABLE_CYCLES);
    assign t_start[T_DISC] = disc_wait;
    assign t_load[T_DISC]  = disc_left;
    // RULE8 - FEC wake delay
    assign t_start[T_TXF]  = tx_start & fec_q;
    assign t_load[T_TXF]   = 32'(TX_FEC_CYCLES);
    // RULE11 - FEC processing delay
    assign t_start[T_RXF]  = rx_full_hit & fec_q;
    assign t_load[T_RXF]   = 32'(RX_FEC_CYCLES);

    generate
        for (genvar t = 0; t < NUM_TIMER; t++)
        begin : g_timer
            event_delay u_delay
            (
                .clock   (clock),
                .sys_rst (sys_rst),
                .start   (t_start[t]),
                .load    (t_load[t]),
                .busy    (t_busy[t]),
                .done    (t_done[t])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    wire ev_clk   = t_done[T_CLK];
    wire ev_disc  = disc_now | t_done[T_DISC];
    wire ev_empty = tx_empty_hit | rx_empty_hit;
    wire ev_full  = tx_full_hit | (rx_full_hit & ~fec_q) | t_done[T_RXF];

    // RULE1 - group one layout
    wire [31:0] loc_set = (32'(ev_clk) << BIT_CLK_STABLE) | (32'(ev_disc) << BIT_DISCARD)
                        | (32'(ev_empty) << BIT_FIFO_EMPTY) | (32'(ev_full) << BIT_FIFO_FULL);
    // RULE2 - radio core events
    // RULE3 - per-FIFO and group four
    wire [31:0] ext_set = {6'h0, evt_pulse} & SRC_EXT_MASK;
    wire [31:0] ev_set  = loc_set | ext_set;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    wire aw_take = awvalid & awready;
    wire w_take  = wvalid & wready;
    wire wr_do   = aw_full_q & w_full_q & ~bvalid;
    wire wa_ok   = wa_q[1:0] == 2'b00;
    wire wa_src  = wa_ok & (wa_q[7:4] == ADDR_SRC_BASE[7:4]);
    wire wa_en   = wa_ok & (wa_q[7:4] == ADDR_EN_BASE[7:4]);
    wire wa_ctrl = wa_q == ADDR_CTRL;
    wire wa_trig = wa_q == ADDR_TRIG;
    wire wa_stat = wa_q == ADDR_STATUS;
    wire wa_hit  = wa_src | wa_en | wa_ctrl | wa_trig | wa_stat;
    wire lane0   = wr_do & ws_q[0];
    wire lane1   = wr_do & ws_q[1];

    wire        aw_full_d = aw_take | (aw_full_q & ~wr_do);
    wire        w_full_d  = w_take | (w_full_q & ~wr_do);
    wire        bvalid_d  = wr_do | (bvalid & ~bready);
    wire [31:0] src_clr;
    wire [31:0] en_next;

    generate
        for (genvar g = 0; g < NUM_GROUPS; g++)
        begin : g_group
            wire sel = wa_q[3:2] == 2'(g);
            // RULE15 - write one clears
            assign src_clr[g*GROUP_W +: GROUP_W] = (lane0 & wa_src & sel) ?
                                                   wd_q[GROUP_W-1:0] : 8'h00;
            // RULE14 - enable group write
            assign en_next[g*GROUP_W +: GROUP_W] = (lane0 & wa_en & sel) ?
                                                   wd_q[GROUP_W-1:0] :
                                                   en_q[g*GROUP_W +: GROUP_W];
        end
    endgenerate

    // RULE4 - latch regardless of mask
    wire [31:0] src_d = ((src_q & ~src_clr) | ev_set) & SRC_IMPL_MASK;
    wire        pend  = |(src_q & en_q);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            wa_q      <= 8'h00;
            wd_q      <= 32'h0;
            ws_q      <= 4'h0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready   <= ~aw_full_d & ~bvalid_d;
            wready    <= ~w_full_d & ~bvalid_d;
            bvalid    <= bvalid_d;
            bresp     <= wr_do ? (wa_hit ? RESP_OKAY : RESP_SLVERR) : bresp;
            wa_q      <= aw_take ? awaddr : wa_q;
            wd_q      <= w_take ? wdata : wd_q;
            ws_q      <= w_take ? wstrb : ws_q;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            src_q        <= 32'h0;
            en_q         <= 32'h0;
            dac_q        <= 1'b0;
            fec_q        <= 1'b0;
            rate_q       <= RATE_100K;
            trig_empty_q <= TRIG_EMPTY_RST;
            trig_full_q  <= TRIG_FULL_RST;
        end
        else
        begin
            src_q        <= src_d;
            en_q         <= en_next & SRC_IMPL_MASK;
            dac_q        <= (lane0 & wa_ctrl) ? wd_q[CTRL_DAC_BIT] : dac_q;
            fec_q        <= (lane0 & wa_ctrl) ? wd_q[CTRL_FEC_BIT] : fec_q;
            rate_q       <= (lane0 & wa_ctrl) ? rate_e'(wd_q[CTRL_RATE_LSB +: 2]) : rate_q;
            trig_empty_q <= (lane0 & wa_trig) ? wd_q[7:0] : trig_empty_q;
            trig_full_q  <= (lane1 & wa_trig) ? wd_q[TRIG_FULL_LSB +: 8] : trig_full_q;
        end
    end

    // ------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------
    // Next values used so unmasking a pending bit acts at once
    // RULE13 - low while unmasked pending
    wire irq_d = |(src_d & en_next);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_out_n <= 1'b1;
        else
            irq_out_n <= ~irq_d;
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    wire ar_take = arvalid & arready;
    wire ra_ok   = araddr[1:0] == 2'b00;
    wire ra_src  = ra_ok & (araddr[7:4] == ADDR_SRC_BASE[7:4]);
    wire ra_en   = ra_ok & (araddr[7:4] == ADDR_EN_BASE[7:4]);
    wire ra_ctrl = araddr == ADDR_CTRL;
    wire ra_trig = araddr == ADDR_TRIG;
    wire ra_stat = araddr == ADDR_STATUS;
    wire ra_hit  = ra_src | ra_en | ra_ctrl | ra_trig | ra_stat;

    wire [4:0]  ra_sh    = {araddr[3:2], 3'b000};
    wire [7:0]  src_rd   = src_q[ra_sh +: GROUP_W];
    wire [7:0]  en_rd    = en_q[ra_sh +: GROUP_W];
    wire [31:0] ctrl_rd  = {28'h0, rate_q, fec_q, dac_q};
    wire [31:0] trig_rd  = {16'h0, trig_full_q, trig_empty_q};
    // Live view of the block's own progress
    wire [31:0] stat_rd  = {7'h0, lvl_q, 8'h0, t_busy, fr_q, 1'b0, pend};
    wire [31:0] rd_word  = ra_src  ? {24'h0, src_rd} :
                           ra_en   ? {24'h0, en_rd}  :
                           ra_ctrl ? ctrl_rd         :
                           ra_trig ? trig_rd         :
                           ra_stat ? stat_rd         : 32'h0;
    wire        rvalid_d = ar_take | (rvalid & ~rready);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
        end
        else
        begin
            arready <= ~rvalid_d;
            rvalid  <= rvalid_d;
            rdata   <= ar_take ? rd_word : rdata;
            rresp   <= ar_take ? (ra_hit ? RESP_OKAY : RESP_SLVERR) : rresp;
        end
    end

endmodule // radio_interrupt_event_unit

// ---- design/radio_irq_pkg.sv ----
// Constants and types shared by the radio interrupt event unit
// Operation
// RULE1 - Group one: clock, VCO, discard, empty, full
// RULE2 - Group two: CCA through TX FIFO error
// RULE3 - Group three per FIFO; group four ack, unlock
// RULE4 - Masked events still latch their source bit
// RULE5 - Clock stable 660us after reset or wake
// RULE6 - Discard flag immediately on address mismatch
// RULE7 - Discard after frame plus processing delay
// RULE8 - TX empty at trigger, FEC wake delay
// RULE9 - RX empty when reads go below trigger
// RULE10 - TX prep full when writes exceed trigger
// RULE11 - RX full after bytes exceed trigger
// RULE12 - Symbol time follows the data rate
// RULE13 - Active-low interrupt while unmasked event pending
// RULE14 - Four enable groups mask the sources
// RULE15 - Host clears each serviced source bit
package radio_irq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int CLK_STABLE_PS    = 660000000;
    localparam int DISC_NOFEC_PS    = 5550000;
    localparam int DISC_FEC_PS      = 315550000;
    localparam int TX_FEC_WAKE_PS   = 106000000;
    localparam int RX_FEC_PROC_PS   = 305000000;
    localparam int SYM_100K_PS      = 10000000;
    localparam int SYM_50K_PS       = 20000000;
    localparam int SYM_200K_PS      = 5000000;
    localparam int SYM_400K_PS      = 2500000;
    // Least times round up to whole cycles
    localparam int CLK_STABLE_CYC   = (CLK_STABLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DISC_NOFEC_CYC   = (DISC_NOFEC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DISC_FEC_CYC     = (DISC_FEC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TX_FEC_WAKE_CYC  = (TX_FEC_WAKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RX_FEC_PROC_CYC  = (RX_FEC_PROC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYM_100K_CYC     = (SYM_100K_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYM_50K_CYC      = (SYM_50K_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYM_200K_CYC     = (SYM_200K_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYM_400K_CYC     = (SYM_400K_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BITS_PER_BYTE_SH = 3;

    // ------------------------------------------------------------
    // Event bit positions
    // ------------------------------------------------------------
    localparam int BIT_CLK_STABLE   = 0;
    localparam int BIT_VCO_CAL      = 2;
    localparam int BIT_DISCARD      = 3;
    localparam int BIT_FIFO_EMPTY   = 4;
    localparam int BIT_FIFO_FULL    = 5;
    localparam int BIT_CCA_DONE     = 8;
    localparam int BIT_TX_FIFO_ERR  = 15;
    localparam int BIT_TX_DONE0     = 16;
    localparam int BIT_TX_ACCEPT1   = 23;
    localparam int BIT_AUTO_ACK     = 24;
    localparam int BIT_PLL_UNLOCK   = 25;
    localparam int NUM_EVENTS       = 26;
    localparam int NUM_GROUPS       = 4;
    localparam int GROUP_W          = 8;
    // Implemented bits; 1, 6, 7 and 26 up read zero
    localparam logic [31:0] SRC_IMPL_MASK = 32'h03FF_FF3D;
    // Events fed straight from the radio core
    localparam logic [31:0] SRC_EXT_MASK  = 32'h03FF_FF04;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SRC_BASE  = 8'h00;
    localparam logic [7:0] ADDR_EN_BASE   = 8'h10;
    localparam logic [7:0] ADDR_CTRL      = 8'h20;
    localparam logic [7:0] ADDR_TRIG      = 8'h24;
    localparam logic [7:0] ADDR_STATUS    = 8'h28;
    localparam int         CTRL_DAC_BIT   = 0;
    localparam int         CTRL_FEC_BIT   = 1;
    localparam int         CTRL_RATE_LSB  = 2;
    localparam int         TRIG_FULL_LSB  = 8;
    localparam logic [7:0] TRIG_EMPTY_RST = 8'h02;
    localparam logic [7:0] TRIG_FULL_RST  = 8'h05;
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    localparam int T_CLK     = 0;
    localparam int T_DISC    = 1;
    localparam int T_TXF     = 2;
    localparam int T_RXF     = 3;
    localparam int NUM_TIMER = 4;

    typedef enum logic [1:0] {
        RATE_100K = 2'b00,
        RATE_50K  = 2'b01,
        RATE_200K = 2'b10,
        RATE_400K = 2'b11
    } rate_e;

    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_RX   = 2'b01,
        FR_HOLD = 2'b10
    } frame_state_e;

endpackage

// ---- verif/radio_core_model.sv ----
// Radio core stand-in that turns a request into one-cycle event pulses
`timescale 1ns/10ps
module radio_core_model
(
    // Clock
    input  wire logic        clock,
    // Request
    input  wire logic        fire,
    input  wire logic [25:0] pattern,
    // Events
    output logic [25:0]      evt_pulse
);
    // Pulses last one cycle; a stuck line would mask set-over-clear faults
    always_ff @(posedge clock)
    begin
        evt_pulse <= fire ? pattern : 26'h0;
    end
endmodule // radio_core_model

// ---- verif/radio_interrupt_event_unit_test.sv ----
// Self-checking bench of the radio interrupt event unit
`timescale 1ns/10ps
module radio_interrupt_event_unit_test
    import radio_irq_pkg::*;
;
    logic clock = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, pin_n = 1, wake = 0, fd = 0, mism = 0, rx_act = 0, fire = 0;
    logic fe = 0, stb = 0, txs = 0, txa = 0;
    logic awready, wready, bvalid, arready, rvalid, irq_out_n;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, p;
    logic [1:0] bresp, rresp;
    logic [8:0] level = 0;
    logic [11:0] fbytes = 0;
    logic [25:0] evt, pat = 0;
    logic [15:0] lf = 16'hA2BE;
    logic [33:0] exp_q[$];
    int fails = 0, n_compared = 0, cyc = 0;
    always #2.5 clock = ~clock;
    radio_core_model core (.clock(clock), .fire(fire), .pattern(pat), .evt_pulse(evt));
    radio_interrupt_event_unit #(.CLK_STABLE_CYCLES(50), .DISC_FEC_CYCLES(40),
        .TX_FEC_CYCLES(30), .RX_FEC_CYCLES(30)) DUT (.clock(clock), .sys_rst(sys_rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .chip_reset_pin_n(pin_n), .sleep_wake(wake), .frame_delimiter(fd),
        .addr_mismatch(mism), .rx_frame_end(fe), .frame_bytes(fbytes),
        .rx_byte_stb(stb), .tx_start(txs), .tx_active(txa), .rx_active(rx_act),
        .fifo_level(level), .evt_pulse(evt), .irq_out_n(irq_out_n));
    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp(input logic [33:0] got, input logic [33:0] e);
        n_compared++;
        if (got !== e)
        begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ta && tw))
        begin
            @(posedge clock);
            if (awready) begin ta = 1; awvalid <= 0; end
            if (wready) begin tw = 1; wvalid <= 0; end
        end
        do @(posedge clock); while (!bvalid);
        cmp({32'h0, bresp}, 34'(RESP_OKAY));
    endtask
    // Expected word noted here, compared by the watcher
    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] e);
        exp_q.push_back({r, e});
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clock); while (!arready);
        arvalid <= 0;
        do @(posedge clock); while (!rvalid);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge clock);
        cmp({33'h0, irq_out_n}, {33'h0, e});
        @(posedge clock);
    endtask
    always @(posedge clock)
    begin
        if (rvalid && rready) cmp({rresp, rdata}, exp_q.pop_front());
        cyc <= cyc + 1;
        if (cyc == 20000) begin fails++; give_verdict(); end
    end
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        tick(8);
        sys_rst <= 0;
        tick(2);
        rd(ADDR_TRIG, RESP_OKAY, 32'h0000_0502);
        rd(8'h30, RESP_SLVERR, 32'h0); // Unmapped place
        tick(60);
        rd(ADDR_SRC_BASE, RESP_OKAY, 32'h1);
        chk_irq(1);
        wr(ADDR_EN_BASE, 32'h01);
        chk_irq(0);
        wr(ADDR_SRC_BASE, 32'hFF);
        chk_irq(1);
        wake <= 1; tick(1); wake <= 0; tick(60);
        rd(ADDR_SRC_BASE, RESP_OKAY, 32'h1);
        wr(ADDR_SRC_BASE, 32'hFF);
        $display("test clock_stable done");
        wr(ADDR_EN_BASE + 8'h0C, 32'h02);
        repeat (3)
        begin
            lf = step(lf); p[15:0] = lf; lf = step(lf); p[31:16] = lf;
            pat <= p[25:0] & SRC_EXT_MASK[25:0]; fire <= 1; tick(1); fire <= 0; tick(3);
            p = p & SRC_EXT_MASK & SRC_IMPL_MASK;
            for (int g = 0; g < 4; g++) rd(8'(4 * g), RESP_OKAY, (p >> (8 * g)) & 32'hFF);
            chk_irq(!p[25]);
            for (int g = 0; g < 4; g++) wr(8'(4 * g), 32'hFF);
            chk_irq(1);
        end
        $display("test event_groups done");
        fd <= 1; tick(1); fd <= 0; fbytes <= lf[11:0]; mism <= 1; tick(1); mism <= 0;
        level <= 9'd6; tick(3);
        rd(ADDR_SRC_BASE, RESP_OKAY, 32'h28);
        rx_act <= 1; level <= 9'd1; tick(3);
        rd(ADDR_SRC_BASE, RESP_OKAY, 32'h38);
        $display("test discard_fifo done");
        give_verdict();
    end
endmodule // radio_interrupt_event_unit_test

// ---- verif/radio_irq_properties.sv ----
// Bus and interrupt line properties of the radio interrupt event unit
`timescale 1ns/10ps
module radio_irq_properties
    import radio_irq_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // Bus handshakes
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    // Interrupt line
    input wire logic        irq_out_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    resp_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    write_answer_a: assert property (wvalid && wready |-> ##[1:3] bvalid)
        else $error("write answer late");
    read_busy_a: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    write_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    err_zero_a: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
        else $error("error read carries data");
    reset_quiet_a: assert property ($past(sys_rst) |-> irq_out_n && !rvalid)
        else $error("outputs busy after reset");
    cover property (bvalid && bready);
    cover property (rvalid && rresp == RESP_SLVERR);
    cover property ($fell(irq_out_n));
endmodule // radio_irq_properties

bind radio_interrupt_event_unit radio_irq_properties chk (.*);
